/* rtl/qed_filt.sv */
// one encoder input: synchroniser and sampled glitch filter
`timescale 1ns/1ps
module qed_filt
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic raw,
   input wire logic tick,
   input wire logic filt_en,
   output logic level
);
   localparam int unsigned FS = qed_pkg::FILT_SAMPLES;
   qed_pkg::qed_filt_s s, n;

   always_comb
   begin
      n = s;
      n.s1 = raw;
      n.s2 = s.s1;
      if (tick)
      begin
         n.hist = {s.hist[FS-2:0], s.s2};
      end
      if (!filt_en)
      begin
         n.lvl = s.s2;
      end
      else if (s.hist == {FS{1'b1}})
      begin
         n.lvl = 1'b1;
      end
      else if (s.hist == {FS{1'b0}})
      begin
         n.lvl = 1'b0;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         s <= '0;
      end
      else
      begin
         s <= n;
      end
   end

   assign level = s.lvl;

   a_filter_bypass: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !filt_en |=> level == $past(raw, 3))
      else $error("bypassed input does not follow pin");
   a_filter_reject: assert property (@(posedge sys_clk) disable iff (sys_rst)
      $changed(level) && $past(filt_en) |-> $past(s.hist) == {FS{level}})
      else $error("filter passed a short pulse");

endmodule // qed_filt

/* rtl/qed_pkg.sv */
// constants, types and helpers shared by the quadrature decoder files
// What this block does
// - filter enable bit routes inputs through filter
// - filter rejects pulses under three filter periods
// - three-bit code picks filter sampling clock
// - x4 index gating by one A/B state
// - x2 index gating by one channel level
// - swap bit exchanges A and B inputs
// - mode field picks x2/x4 and reset source
// - index clears counter only in index modes
// - signed 32-bit index tally at two words
// - index steps tally by phase direction
// - position counter readable at its offset
// - counts transitions correctly up to 3.3 MHz
// - registers reached by serial read/write functions
package qed_pkg;

   // ***************************************************************
   // clock and timing
   // ***************************************************************
   localparam int unsigned SYS_HZ = 25_000_000;
   localparam int unsigned FILT_HZ [8] = '{40_000_000, 20_000_000,
      10_000_000, 2_500_000, 1_250_000, 625_000, 312_500, 156_250};
   // four equal samples span three filter periods
   localparam int unsigned FILT_SAMPLES = 4;
   localparam int unsigned BAUD_HZ = 9600;
   localparam logic [15:0] BAUD_DIV = 16'(SYS_HZ / BAUD_HZ);
   // end of frame: 3.5 characters of 11 bits, kept in half bits
   localparam int unsigned GAP_HALF_BITS = 77;
   localparam int unsigned GAP_CYC_DEF =
      (GAP_HALF_BITS * SYS_HZ / BAUD_HZ) / 2;

   // ***************************************************************
   // register map and fields
   // ***************************************************************
   localparam logic [15:0] REG_SETUP = 16'h000c;
   localparam logic [15:0] REG_LIMIT = 16'h000d;
   localparam logic [15:0] REG_IDX_HI = 16'h000e;
   localparam logic [15:0] REG_IDX_LO = 16'h000f;
   localparam logic [15:0] REG_POS = 16'h0010;
   localparam int unsigned F_FILT_EN = 9;
   localparam int unsigned F_FREQ_LSB = 6;
   localparam int unsigned F_GATE_LSB = 4;
   localparam int unsigned F_SWAP = 3;
   localparam int unsigned F_MODE_LSB = 1;
   localparam int unsigned F_IDX_EN = 0;
   localparam logic [15:0] SETUP_RST = 16'h0000;
   localparam logic [15:0] LIMIT_RST = 16'h0000;

   // ***************************************************************
   // serial protocol
   // ***************************************************************
   localparam logic [7:0] FN_READ = 8'h03;
   localparam logic [7:0] FN_WRITE = 8'h06;
   localparam logic [7:0] EXC_FN = 8'h01;
   localparam logic [7:0] EXC_ADDR = 8'h02;
   localparam logic [7:0] EXC_FLAG = 8'h80;
   localparam logic [15:0] CRC_INIT = 16'hffff;
   localparam logic [15:0] CRC_POLY = 16'ha001;
   localparam logic [3:0] REQ_LEN = 4'h8;
   localparam logic [7:0] ECHO_LEN = 8'h08;
   localparam logic [7:0] EXC_LEN = 8'h05;
   localparam logic [7:0] READ_OVH = 8'h05;

   typedef struct packed {
      logic idx;
      logic b;
      logic a;
   } qed_abi_s;

   typedef struct packed {
      logic rx_s1;
      logic rx_s2;
      logic rx_busy;
      logic [15:0] rx_cnt;
      logic [3:0] rx_bit;
      logic [7:0] rx_sh;
      logic [7:0] rx_data;
      logic rx_vld;
      logic tx_busy;
      logic [15:0] tx_cnt;
      logic [3:0] tx_bit;
      logic [9:0] tx_sh;
   } qed_uart_s;

   typedef struct packed {
      logic s1;
      logic s2;
      logic [FILT_SAMPLES-1:0] hist;
      logic lvl;
   } qed_filt_s;

   function automatic logic [7:0] filt_div(input logic [2:0] code);
      int unsigned f;
      f = FILT_HZ[code];
      filt_div = 8'((SYS_HZ + f - 1) / f);
   endfunction

   function automatic logic [15:0] crc_upd(input logic [15:0] c,
                                           input logic [7:0] d);
      logic [15:0] r;
      r = c ^ {8'h00, d};
      for (int i = 0; i < 8; i++)
      begin
         r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      crc_upd = r;
   endfunction

endpackage

/* rtl/qed_top.sv */
// quadrature decoder with its serial register access
`timescale 1ns/1ps
module qed_top
#(
   parameter int unsigned GAP_CYC = qed_pkg::GAP_CYC_DEF,
   parameter logic [15:0] BIT_CYC = qed_pkg::BAUD_DIV
)
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic enc_a,
   input wire logic enc_b,
   input wire logic enc_idx,
   input wire logic [7:0] node_addr,
   input wire logic rs485_rx,
   output logic rs485_tx,
   output logic rs485_de
);
   typedef enum logic [1:0] {ST_RX, ST_SEND, ST_WAIT} qed_link_e;
   typedef enum logic [1:0] {RESP_READ, RESP_ECHO, RESP_EXC} qed_resp_e;
   typedef struct packed {
      logic [15:0] setup;
      logic [15:0] limit;
      logic [15:0] pos;
      logic [31:0] tally;
      logic a_p;
      logic b_p;
      logic i_p;
      logic dir;
      logic [7:0] fdiv;
      logic tick;
      logic [19:0] gap;
      logic [7:0][7:0] rbuf;
      logic [3:0] rlen;
      logic ovf;
      logic [15:0] rcrc;
      qed_link_e st;
      qed_resp_e kind;
      logic [7:0] exc;
      logic [7:0] tidx;
      logic [7:0] tlen;
      logic [15:0] tcrc;
      logic tx_start;
      logic [7:0] tx_byte;
   } qed_main_s;

   qed_main_s s, n;
   qed_pkg::qed_abi_s raw, filt;
   logic [7:0] rx_data, tb;
   logic rx_vld, tx_busy;
   logic filt_en, swap, x4, match, idx_en;
   logic [2:0] fcode;
   logic [1:0] gate;
   logic a, b, step, up, gate_ok, idx_ev, idx_clr;
   logic [15:0] ra, val, word;
   logic [16:0] rd_end;
   logic [7:0] k;

   // ***************************************************************
   // configuration fields
   // ***************************************************************
   assign filt_en = s.setup[qed_pkg::F_FILT_EN];
   assign fcode = s.setup[qed_pkg::F_FREQ_LSB +: 3];
   assign gate = s.setup[qed_pkg::F_GATE_LSB +: 2];
   assign swap = s.setup[qed_pkg::F_SWAP];
   assign x4 = s.setup[qed_pkg::F_MODE_LSB + 1];
   assign match = s.setup[qed_pkg::F_MODE_LSB];
   assign idx_en = s.setup[qed_pkg::F_IDX_EN];
   assign raw = '{idx: enc_idx, b: enc_b, a: enc_a};
   assign ra = {s.rbuf[2], s.rbuf[3]};
   assign val = {s.rbuf[4], s.rbuf[5]};
   assign rd_end = {1'b0, ra} + {1'b0, val};

   // ***************************************************************
   // input filters
   // ***************************************************************
   for (genvar g = 0; g < 3; g++)
   begin : g_filt
      qed_filt u_filt
      (
         .sys_clk(sys_clk),
         .sys_rst(sys_rst),
         .raw(raw[g]),
         .tick(s.tick),
         .filt_en(filt_en),
         .level(filt[g])
      );
   end

   qed_uart #(.DIV(BIT_CYC)) u_uart
   (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .rx_pin(rs485_rx),
      .rx_data(rx_data),
      .rx_vld(rx_vld),
      .tx_data(s.tx_byte),
      .tx_start(s.tx_start),
      .tx_busy(tx_busy),
      .tx_pin(rs485_tx)
   );

   function automatic logic [15:0] reg_rd(input logic [15:0] adr,
                                          input qed_main_s v);
      unique case (adr)
         qed_pkg::REG_SETUP: reg_rd = v.setup;
         qed_pkg::REG_LIMIT: reg_rd = v.limit;
         qed_pkg::REG_IDX_HI: reg_rd = v.tally[31:16];
         qed_pkg::REG_IDX_LO: reg_rd = v.tally[15:0];
         qed_pkg::REG_POS: reg_rd = v.pos;
         default: reg_rd = 16'h0000;
      endcase
   endfunction

   // ***************************************************************
   // response byte
   // ***************************************************************
   always_comb
   begin
      k = s.tidx - 8'h03;
      word = reg_rd(ra + {8'h00, 1'b0, k[7:1]}, s);
      if (s.tidx == s.tlen - 8'h02)
         tb = s.tcrc[7:0];
      else if (s.tidx == s.tlen - 8'h01)
         tb = s.tcrc[15:8];
      else if (s.kind == RESP_ECHO)
         tb = s.rbuf[s.tidx[2:0]];
      else if (s.tidx == 8'h00)
         tb = s.rbuf[0];
      else if (s.tidx == 8'h01)
         tb = (s.kind == RESP_EXC) ? (s.rbuf[1] | qed_pkg::EXC_FLAG)
                                   : s.rbuf[1];
      else if (s.tidx == 8'h02)
         tb = (s.kind == RESP_EXC) ? s.exc : s.tlen - qed_pkg::READ_OVH;
      else
         tb = k[0] ? word[7:0] : word[15:8];
   end

   // ***************************************************************
   // next state
   // ***************************************************************
   always_comb
   begin
      n = s;
      n.tick = 1'b0;
      n.tx_start = 1'b0;
      if (s.fdiv == 8'h00)
      begin
         n.tick = 1'b1;
         n.fdiv = qed_pkg::filt_div(fcode) - 8'h01;
      end
      else
      begin
         n.fdiv = s.fdiv - 8'h01;
      end

      // decoder; 2 sync stages leave ample margin at 3.3 MHz edges
      a = swap ? filt.b : filt.a;
      b = swap ? filt.a : filt.b;
      n.a_p = a;
      n.b_p = b;
      n.i_p = filt.idx;
      if (x4)
      begin
         step = (a ^ s.a_p) ^ (b ^ s.b_p);
         up = a ^ s.b_p;
         gate_ok = ({b, a} == gate);
      end
      else
      begin
         step = (a ^ s.a_p) && (b == s.b_p);
         up = a ^ b;
         gate_ok = gate[1] ? (b == gate[0]) : (a == gate[0]);
      end
      if (step)
         n.dir = up;
      idx_ev = filt.idx && !s.i_p && gate_ok;
      idx_clr = idx_ev && idx_en && !match;
      if (idx_ev)
         n.tally = n.dir ? s.tally + 32'h1 : s.tally - 32'h1;
      if (idx_clr)
         n.pos = 16'h0000;
      else if (step && match)
         n.pos = up ? ((s.pos == s.limit) ? 16'h0000 : s.pos + 16'h1)
                    : ((s.pos == 16'h0000) ? s.limit : s.pos - 16'h1);
      else if (step)
         n.pos = up ? s.pos + 16'h1 : s.pos - 16'h1;

      // serial frames: one request at a time, half duplex
      unique case (s.st)
         ST_RX:
         begin
            if (rx_vld)
            begin
               n.gap = '0;
               if (s.rlen < qed_pkg::REQ_LEN)
               begin
                  n.rbuf[s.rlen[2:0]] = rx_data;
                  n.rcrc = qed_pkg::crc_upd(s.rcrc, rx_data);
                  n.rlen = s.rlen + 4'h1;
               end
               else
               begin
                  n.ovf = 1'b1;
               end
            end
            else if (s.gap != GAP_CYC[19:0])
            begin
               n.gap = s.gap + 20'h1;
            end
            else if (s.rlen != 4'h0)
            begin
               n.rlen = 4'h0;
               n.ovf = 1'b0;
               n.rcrc = qed_pkg::CRC_INIT;
               // a bad checksum or foreign address gets no answer
               if (s.rlen == qed_pkg::REQ_LEN && !s.ovf &&
                   s.rcrc == 16'h0000 && s.rbuf[0] == node_addr)
               begin
                  n.st = ST_SEND;
                  n.tidx = 8'h00;
                  n.tcrc = qed_pkg::CRC_INIT;
                  n.kind = RESP_EXC;
                  n.tlen = qed_pkg::EXC_LEN;
                  n.exc = qed_pkg::EXC_ADDR;
                  if (s.rbuf[1] == qed_pkg::FN_READ)
                  begin
                     if (ra >= qed_pkg::REG_SETUP && val != 16'h0000 &&
                         rd_end <= {1'b0, qed_pkg::REG_POS} + 17'h1)
                     begin
                        n.kind = RESP_READ;
                        n.tlen = qed_pkg::READ_OVH + {val[6:0], 1'b0};
                     end
                  end
                  else if (s.rbuf[1] == qed_pkg::FN_WRITE)
                  begin
                     if (ra == qed_pkg::REG_SETUP)
                     begin
                        n.setup = val;
                        n.kind = RESP_ECHO;
                        n.tlen = qed_pkg::ECHO_LEN;
                     end
                     else if (ra == qed_pkg::REG_LIMIT)
                     begin
                        n.limit = val;
                        n.kind = RESP_ECHO;
                        n.tlen = qed_pkg::ECHO_LEN;
                     end
                  end
                  else
                  begin
                     n.exc = qed_pkg::EXC_FN;
                  end
               end
            end
         end
         ST_SEND:
         begin
            n.tx_start = 1'b1;
            n.tx_byte = tb;
            n.st = ST_WAIT;
         end
         ST_WAIT:
         begin
            if (!s.tx_start && !tx_busy)
            begin
               // checksum bytes themselves stay out of the sum
               if (s.tidx < s.tlen - 8'h02)
                  n.tcrc = qed_pkg::crc_upd(s.tcrc, s.tx_byte);
               n.tidx = s.tidx + 8'h01;
               n.st = (s.tidx + 8'h01 == s.tlen) ? ST_RX : ST_SEND;
            end
         end
         default: n.st = ST_RX;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         s <= '0;
         s.setup <= qed_pkg::SETUP_RST;
         s.limit <= qed_pkg::LIMIT_RST;
         s.rcrc <= qed_pkg::CRC_INIT;
         s.st <= ST_RX;
      end
      else
      begin
         s <= n;
      end
   end

   assign rs485_de = tx_busy;

   // ***************************************************************
   // checks
   // ***************************************************************
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);

   a_tick_rate: assert property (
      s.tick && fcode == 3'h3 && $stable(s.setup) |=>
         !s.tick [*8] ##1 !s.tick ##1 s.tick)
      else $error("filter clock divide wrong for code 3");
   a_gate_x4: assert property (
      x4 && filt.idx && !s.i_p && {b, a} != gate |=> $stable(s.tally))
      else $error("ungated index moved tally in x4");
   a_gate_x2: assert property (
      !x4 && filt.idx && !s.i_p && (gate[1] ? b : a) != gate[0]
         |=> $stable(s.tally))
      else $error("ungated index moved tally in x2");
   a_index_clear: assert property (
      idx_ev && idx_en && !match |=> s.pos == 16'h0000)
      else $error("index did not clear counter");
   a_index_kept: assert property (
      idx_ev && match && !step |=> $stable(s.pos))
      else $error("index touched counter in match mode");
   a_tally_step: assert property (
      idx_ev |=> s.tally == $past(s.tally) + 32'h1 ||
                 s.tally == $past(s.tally) - 32'h1)
      else $error("tally did not step by one");
   a_wrap_up: assert property (
      step && up && match && !idx_clr && s.pos == s.limit
         |=> s.pos == 16'h0000)
      else $error("counter did not wrap at limit");
   a_free_count: assert property (
      step && up && !match && !idx_clr |=> s.pos == $past(s.pos) + 16'h1)
      else $error("forward edge not counted");
   a_send_bound: assert property (
      s.st == ST_SEND |-> ##[1:3] tx_busy)
      else $error("response byte not started");

endmodule // qed_top

/* rtl/qed_uart.sv */
// 8n1 serial receiver and transmitter for the rs485 link
`timescale 1ns/1ps
module qed_uart
#(
   parameter logic [15:0] DIV = qed_pkg::BAUD_DIV
)
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic rx_pin,
   output logic [7:0] rx_data,
   output logic rx_vld,
   input wire logic [7:0] tx_data,
   input wire logic tx_start,
   output logic tx_busy,
   output logic tx_pin
);
   qed_pkg::qed_uart_s s, n;

   always_comb
   begin
      n = s;
      n.rx_s1 = rx_pin;
      n.rx_s2 = s.rx_s1;
      n.rx_vld = 1'b0;
      if (!s.rx_busy)
      begin
         if (!s.rx_s2)
         begin
            n.rx_busy = 1'b1;
            n.rx_cnt = DIV >> 1;
            n.rx_bit = 4'h0;
         end
      end
      else if (s.rx_cnt != 16'h0000)
      begin
         n.rx_cnt = s.rx_cnt - 16'h0001;
      end
      else
      begin
         n.rx_cnt = DIV - 16'h0001;
         n.rx_bit = s.rx_bit + 4'h1;
         if (s.rx_bit == 4'h0)
         begin
            n.rx_busy = !s.rx_s2; // glitch on start bit aborts
         end
         else if (s.rx_bit == 4'h9)
         begin
            n.rx_busy = 1'b0;
            n.rx_data = s.rx_sh;
            n.rx_vld = s.rx_s2; // framing error drops the byte
         end
         else
         begin
            n.rx_sh = {s.rx_s2, s.rx_sh[7:1]};
         end
      end
      if (!s.tx_busy)
      begin
         if (tx_start)
         begin
            n.tx_sh = {1'b1, tx_data, 1'b0};
            n.tx_bit = 4'h0;
            n.tx_cnt = DIV - 16'h0001;
            n.tx_busy = 1'b1;
         end
      end
      else if (s.tx_cnt != 16'h0000)
      begin
         n.tx_cnt = s.tx_cnt - 16'h0001;
      end
      else
      begin
         n.tx_cnt = DIV - 16'h0001;
         n.tx_sh = {1'b1, s.tx_sh[9:1]};
         n.tx_bit = s.tx_bit + 4'h1;
         n.tx_busy = (s.tx_bit != 4'h9);
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         s <= '0;
         s.rx_s1 <= 1'b1;
         s.rx_s2 <= 1'b1;
         s.tx_sh <= 10'h3ff;
      end
      else
      begin
         s <= n;
      end
   end

   assign rx_data = s.rx_data;
   assign rx_vld = s.rx_vld;
   assign tx_busy = s.tx_busy;
   assign tx_pin = s.tx_sh[0];

   a_line_idle: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !tx_busy |-> tx_pin)
      else $error("line not idle high between characters");

endmodule // qed_uart

/* sim/qed_enc_model.sv */
// encoder model: two phases, index pulse and index glitch
`timescale 1ns/1ps
module qed_enc_model
(
   input wire logic sys_clk,
   output logic ch_a,
   output logic ch_b,
   output logic ch_i
);
   // ****************
   // phase stepping
   // ****************
   logic [1:0] ph = 2'h0;
   initial
   begin
      ch_a = 1'b0;
      ch_b = 1'b0;
      ch_i = 1'b0;
   end
   // {b,a} runs 00,01,11,10 forward: a leads; gap of 12 or more
   // cycles keeps edges far below the top input rate
   task automatic step(input logic fwd, input int gap);
      ph = fwd ? ph + 2'h1 : ph - 2'h1;
      @(posedge sys_clk);
      ch_a <= ph[1] ^ ph[0];
      ch_b <= ph[1];
      repeat (gap) @(posedge sys_clk);
   endtask
   // index held long enough to pass the filter
   task automatic pulse_idx();
      @(posedge sys_clk);
      ch_i <= 1'b1;
      repeat (16) @(posedge sys_clk);
      ch_i <= 1'b0;
      repeat (16) @(posedge sys_clk);
   endtask
   // two-cycle spike, too short for the filter
   task automatic glitch();
      @(posedge sys_clk);
      ch_i <= 1'b1;
      repeat (2) @(posedge sys_clk);
      ch_i <= 1'b0;
      repeat (16) @(posedge sys_clk);
   endtask
endmodule // qed_enc_model

/* sim/quadrature_encoder_decoder_test.sv */
// self-checking bench for the quadrature decoder
`timescale 1ns/1ps
module quadrature_encoder_decoder_test;
   // ****************
   // signals
   // ****************
   localparam int GAP = 200;
   // short bit time keeps the run brief; the link logic is unchanged
   localparam int BIT = 16;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic rs485_rx = 1'b1;
   logic rs485_tx;
   logic rs485_de;
   logic ma;
   logic mb;
   logic mi;
   logic [31:0] seed = 32'h67e617ba;
   int n_mismatch = 0;
   int comparisons = 0;
   always #20 sys_clk = ~sys_clk;
   qed_enc_model qed_enc_model_inst (.sys_clk(sys_clk), .ch_a(ma),
      .ch_b(mb), .ch_i(mi));
   // pins crossed on purpose: the swap bit has to undo it
   qed_top #(.GAP_CYC(GAP), .BIT_CYC(16'(BIT))) qed_top_inst
      (.sys_clk(sys_clk),
      .sys_rst(sys_rst), .enc_a(mb), .enc_b(ma), .enc_idx(mi),
      .node_addr(8'h01), .rs485_rx(rs485_rx), .rs485_tx(rs485_tx),
      .rs485_de(rs485_de));
   // ****************
   // helpers
   // ****************
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [15:0] crc(input logic [7:0] b [$]);
      logic [15:0] c;
      c = 16'hffff;
      foreach (b[i])
      begin
         c ^= {8'h00, b[i]};
         for (int k = 0; k < 8; k++)
            c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
      end
      return c;
   endfunction
   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic results();
      $display("mismatches %0d comparisons %0d", n_mismatch,
         comparisons);
      if (n_mismatch == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // ****************
   // serial link
   // ****************
   task automatic tx_byte(input logic [7:0] d);
      logic [9:0] f;
      f = {1'b1, d, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         rs485_rx <= f[i];
         repeat (BIT) @(posedge sys_clk);
      end
   endtask
   // sampled on falling edges, clear of the design's updates
   task automatic rx_chk(input logic [7:0] exp);
      logic [7:0] d;
      int n;
      n = 0;
      while (rs485_tx !== 1'b0 && n < 2000)
      begin
         @(negedge sys_clk);
         n++;
      end
      if (n == 2000)
      begin
         n_mismatch++;
         $display("BAD %0t no answer", $time);
      end
      repeat (BIT / 2) @(negedge sys_clk);
      cmp8({7'h00, rs485_de}, 8'h01);
      for (int i = 0; i < 8; i++)
      begin
         repeat (BIT) @(negedge sys_clk);
         d[i] = rs485_tx;
      end
      repeat (BIT) @(negedge sys_clk);
      cmp8({7'h00, rs485_tx}, 8'h01);
      cmp8(d, exp);
   endtask
   task automatic xfer(input logic [7:0] rq [$],
                       input logic [7:0] rs [$]);
      logic [15:0] c;
      c = crc(rq);
      rq.push_back(c[7:0]);
      rq.push_back(c[15:8]);
      c = crc(rs);
      rs.push_back(c[7:0]);
      rs.push_back(c[15:8]);
      // let the last answer's stop bit finish: the link is half duplex
      repeat (BIT) @(posedge sys_clk);
      foreach (rq[i])
         tx_byte(rq[i]);
      foreach (rs[i])
         rx_chk(rs[i]);
   endtask
   // ****************
   // main sequence
   // ****************
   initial
   begin
      logic [15:0] pos;
      logic [1:0] ph;
      int k;
      int m;
      int j;
      repeat (10) @(posedge sys_clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge sys_clk);
      // filter on code 0, gate 3, swap, x4 index mode, index clear
      xfer('{8'h01, 8'h06, 8'h00, 8'h0c, 8'h02, 8'h3d},
           '{8'h01, 8'h06, 8'h00, 8'h0c, 8'h02, 8'h3d});
      k = 4 * int'(rnd() % 8) + 2;
      m = int'(rnd() % 40);
      j = int'(rnd() % 60);
      for (int i = 0; i < k; i++)
         qed_enc_model_inst.step(1'b1, 12 + int'(rnd() % 8));
      qed_enc_model_inst.glitch();
      qed_enc_model_inst.pulse_idx();
      qed_enc_model_inst.step(1'b1, 12);
      qed_enc_model_inst.pulse_idx();
      for (int i = 0; i < m; i++)
         qed_enc_model_inst.step(1'b1, 12 + int'(rnd() % 8));
      for (int i = 0; i < j; i++)
         qed_enc_model_inst.step(1'b0, 12 + int'(rnd() % 8));
      pos = 16'(1 + m - j);
      // one read spans all five registers, so tally halves agree
      xfer('{8'h01, 8'h03, 8'h00, 8'h0c, 8'h00, 8'h05},
           '{8'h01, 8'h03, 8'h0a, 8'h02, 8'h3d, 8'h00, 8'h00,
             8'h00, 8'h00, 8'h00, 8'h01,
             pos[15:8], pos[7:0]});
      xfer('{8'h01, 8'h03, 8'h00, 8'h11, 8'h00, 8'h01},
           '{8'h01, 8'h83, 8'h02});
      // x2 wrap mode, filter off, code 3, gate 3, swap kept, limit 5
      xfer('{8'h01, 8'h06, 8'h00, 8'h0d, 8'h00, 8'h05},
           '{8'h01, 8'h06, 8'h00, 8'h0d, 8'h00, 8'h05});
      xfer('{8'h01, 8'h06, 8'h00, 8'h0c, 8'h00, 8'hfb},
           '{8'h01, 8'h06, 8'h00, 8'h0c, 8'h00, 8'hfb});
      // forward from an even phase is the only a edge with b steady
      ph = 2'(3 + m - j);
      for (int i = 0; i < 12; i++)
      begin
         if (!ph[0])
            pos = (pos == 16'h0005) ? 16'h0000 : pos + 16'h0001;
         ph = ph + 2'h1;
         qed_enc_model_inst.step(1'b1, 12 + int'(rnd() % 8));
      end
      // gate 3 in x2 passes the index only while b is high
      qed_enc_model_inst.pulse_idx();
      xfer('{8'h01, 8'h03, 8'h00, 8'h0e, 8'h00, 8'h03},
           '{8'h01, 8'h03, 8'h06, 8'h00, 8'h00, 8'h00,
             ph[1] ? 8'h02 : 8'h01, pos[15:8], pos[7:0]});
      results();
   end
   // about 103 characters of 160 cycles plus encoder traffic; this
   // bound leaves over twice the expected span
   initial
   begin
      repeat (50000) @(posedge sys_clk);
      n_mismatch++;
      results();
   end
endmodule // quadrature_encoder_decoder_test
